// >>> rtl/bridge_pkg.sv
package bridge_pkg;
  // -------------------------------------------------------------
  // register map of the plain register port
  // -------------------------------------------------------------
  localparam logic [7:0] CFG_OFS = 8'h00; // config, read/write
  localparam logic [7:0] STAT_OFS = 8'h04; // status, read only
  localparam logic [7:0] UNMAPPED_RD = 8'h00; // answer to unknown offset
  // config fields
  localparam int CFG_MIRROR_BIT = 0; // i/o address mirroring on
  localparam int CFG_ONBOARD_IRQ_ENABLE_BIT = 1; // on-board vectored response on
  localparam logic [1:0] CFG_RESET = 2'h3; // both options on
  // status fields
  localparam int ST_LVL_LSB = 0; // latched level, 3 bits
  localparam int ST_PEND_BIT = 3; // a level is requesting
  localparam int ST_WAIT_BIT = 4; // processor held in wait
  localparam int ST_HALT_BIT = 5; // processor halted
  // -------------------------------------------------------------
  // restart opcode framing and interrupt levels
  // -------------------------------------------------------------
  localparam int NUM_LEVELS = 8;
  localparam logic [1:0] RST_OP_HI = 2'h3; // bits 7:6
  localparam logic [2:0] RST_OP_LO = 3'h7; // bits 2:0
  // pin sync bundle layout
  localparam int SY_STA = 0; // status-disable, active low
  localparam int SY_SSW = 1; // sense-switch disable
  localparam int SY_XRDY = 2;
  localparam int SY_PRDY = 3;
  localparam int SY_VI = 4; // 8 request lines, active low
  localparam int SY_DI = 12; // backplane input data
  localparam int SY_CP = 20; // panel data
  localparam int SY_W = 28;
endpackage

// >>> rtl/cpu_backplane_bridge.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
// What this block does
// R01 - psync high between memory/io cycles
// R02 - pwait high while ready-caused wait lasts
// R03 - write strobe low only with valid data
// R04 - shlta follows processor halt
// R05 - smemr, sinp, sout only in own cycles
// R06 - sinta through each interrupt acknowledge
// R07 - sm1 on every opcode fetch
// R08 - sstack always false
// R09 - swo while driving output data bus
// R10 - sense-switch disable swaps input to panel
// R11 - status-disable releases status drivers
// R12 - xrdy low forces wait states
// R13 - only one board drives xrdy
// R14 - panel to cpu in panel ops, else reverse
// R15 - input bus on reads except rom, acknowledge
// R16 - cpu data to output bus on writes
// R17 - rom select drives data, input bus off
// R18 - full address outside io cycles
// R19 - mirrored low byte in io cycles
// R20 - latch requests on acknowledge, priority encode
// R21 - vector mux places restart opcode
// R22 - pending drives interrupt only when enabled
// R23 - prdy low forces wait states
// R24 - option selects io address mirroring
// R25 - option disables on-board vectored response
// R26 - pinte deasserts briefly per acknowledge
// R27 - active-low levels, zero highest, bits 5:3
// R28 - unmirrored io cycles drive full address
module cpu_backplane_bridge (
  input wire logic ref_clk,
  input wire logic rst_b,
  // processor side, same clock
  input wire logic [15:0] cpu_address_bus,
  input wire logic [7:0] cpu_data_in, // processor data bus as driven by cpu
  input wire logic cpu_m1_n,
  input wire logic cpu_mreq_n,
  input wire logic cpu_iorq_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic cpu_halt_n,
  input wire logic rom_addr_hit, // external rom decode result
  output logic [7:0] cpu_data_bus, // data toward the processor
  output logic cpu_data_oe,
  output logic cpu_wait_n,
  output logic cpu_int_n,
  // backplane pins, asynchronous
  input wire logic prdy,
  input wire logic xrdy,
  input wire logic ssw_dsbl,
  input wire logic sta_dsbl_n,
  input wire logic [7:0] vi_n,
  input wire logic [7:0] bus_din,
  input wire logic [7:0] panel_din,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_dout,
  output logic bus_dout_oe,
  output logic [7:0] panel_data_bus,
  output logic panel_data_oe,
  output logic psync,
  output logic pwait,
  output logic pwr_n,
  output logic pinte_n,
  output logic smemr,
  output logic sinp,
  output logic sout,
  output logic sinta,
  output logic sm1,
  output logic shlta,
  output logic swo,
  output logic sstack,
  output logic status_oe,
  // gate strobes
  output logic panel_to_cpu_gate,
  output logic bus_in_to_cpu_gate,
  output logic boot_rom_select,
  output logic vector_mux_enable,
  output logic any_level_pending,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  // the rest of the design sees reset only through this copy
  logic [1:0] rst_sync_r; // release pipeline
  logic rst_n; // synchronised reset, active low

  // async assert, release after two edges
  // the release is timed to ref_clk so no flop sees it mid-setup
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  // all state of the bridge but the reset release pipeline in one word, registered in one place
  typedef struct packed {
    logic [bridge_pkg::SY_W-1:0] sy1; // first stage, only feeds sy2
    logic [bridge_pkg::SY_W-1:0] sy2; // usable pin copies
    logic cfg_mirror;
    logic cfg_onboard_irq_enable;
    logic [7:0] rdata;
    logic psync;
    logic pwait;
    logic pwr_n;
    logic smemr;
    logic sinp;
    logic sout;
    logic sinta;
    logic sm1;
    logic shlta;
    logic swo;
    logic sta_oe;
    logic [15:0] addr;
    logic [7:0] cpu_dout;
    logic cpu_doe;
    logic [7:0] bus_dout;
    logic bus_doe;
    logic [7:0] panel_dout;
    logic panel_oe;
    logic panel_gate;
    logic bus_gate;
    logic rom_sel;
    logic mux_en;
    logic pending;
    logic int_n;
    logic irq_ack_condition_d; // acknowledge seen last cycle
    logic pinte_n;
    logic [2:0] lvl; // latched winning level
  } state_s;

  state_s st_r; // registered state
  state_s st_nxt; // next state

  // lowest active index wins, level 0 is highest
  function automatic logic [2:0] prio_enc(input logic [7:0] req);
    logic [2:0] code;
    code = 3'h0;
    for (int i = bridge_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      if (req[i]) begin
        code = i[2:0];
      end
    end
    return code;
  endfunction

  // decoded cpu cycle types, same clock so used directly
  logic mem_cyc;
  logic io_cyc;
  logic irq_ack_condition;
  logic rd_cyc;
  logic wr_cyc;
  logic ready;
  logic panel_op;
  logic irq_ack_condition_rise;
  logic [7:0] vi_act; // requests, active high
  logic [2:0] vec_lvl; // level for this acknowledge

  assign mem_cyc = !cpu_mreq_n;
  assign io_cyc = !cpu_iorq_n && cpu_m1_n;
  assign irq_ack_condition = !cpu_iorq_n && !cpu_m1_n;
  assign rd_cyc = !cpu_rd_n && (mem_cyc || io_cyc);
  assign wr_cyc = !cpu_wr_n && (mem_cyc || io_cyc);
  // both ready lines must be high to run
  assign ready = st_r.sy2[bridge_pkg::SY_PRDY] && st_r.sy2[bridge_pkg::SY_XRDY];
  // panel owns input cycles while sense switches are read
  assign panel_op = st_r.sy2[bridge_pkg::SY_SSW] && io_cyc && !cpu_rd_n;
  // first cycle of an acknowledge, when the levels are latched
  assign irq_ack_condition_rise = irq_ack_condition && !st_r.irq_ack_condition_d;
  // request pins are active low; flip once here for the encoder
  assign vi_act = ~st_r.sy2[bridge_pkg::SY_VI +: 8];
  assign vec_lvl = irq_ack_condition_rise ? prio_enc(vi_act) : st_r.lvl; // R20

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  // one pass computes every next value from the current state
  always_comb begin
    st_nxt = st_r;
    // pins pass two flops before anyone reads them
    st_nxt.sy1 = {panel_din, bus_din, vi_n, prdy, xrdy, ssw_dsbl, sta_dsbl_n};
    st_nxt.sy2 = st_r.sy1;
    // bus strobes
    st_nxt.psync = cpu_mreq_n && cpu_iorq_n; // R01
    // pwait trails cpu_wait_n by one cycle, registered from ready but only in mreq or iorq cycles
    st_nxt.pwait = (mem_cyc || !cpu_iorq_n) && !ready; // R02
    st_nxt.pwr_n = !wr_cyc; // R03
    // status lines
    st_nxt.smemr = mem_cyc && !cpu_rd_n; // R05
    st_nxt.sinp = io_cyc && !cpu_rd_n; // R05
    st_nxt.sout = io_cyc && !cpu_wr_n; // R05
    st_nxt.sinta = irq_ack_condition; // R06
    st_nxt.sm1 = !cpu_m1_n && mem_cyc; // R07
    st_nxt.shlta = !cpu_halt_n; // R04
    st_nxt.swo = wr_cyc; // R09
    // status lines are released, not cleared, by status-disable
    st_nxt.sta_oe = st_r.sy2[bridge_pkg::SY_STA]; // R11
    // address path
    // acknowledge cycles also drop iorq, but they carry no port address
    if (io_cyc && st_r.cfg_mirror) begin
      st_nxt.addr = {cpu_address_bus[7:0], cpu_address_bus[7:0]}; // R19 R24
    end else begin
      st_nxt.addr = cpu_address_bus; // R18 R28
    end
    // data steering
    st_nxt.panel_gate = panel_op; // R10 R14
    st_nxt.rom_sel = rom_addr_hit && mem_cyc && !cpu_rd_n; // R17
    // a rom hit only counts in memory reads; io reads keep the input bus
    st_nxt.bus_gate = rd_cyc && !st_nxt.rom_sel && !panel_op; // R15 R10
    st_nxt.mux_en = irq_ack_condition && st_r.cfg_onboard_irq_enable; // R21 R25
    st_nxt.panel_oe = !panel_op; // R14
    st_nxt.panel_dout = cpu_data_in;
    st_nxt.bus_doe = wr_cyc; // R16
    st_nxt.bus_dout = cpu_data_in; // R16
    // only one source reaches the processor bus in any cycle
    st_nxt.cpu_doe = st_nxt.mux_en || st_nxt.panel_gate || st_nxt.bus_gate;
    if (st_nxt.mux_en) begin
      // restart opcode, level in bits 5:3
      st_nxt.cpu_dout = {bridge_pkg::RST_OP_HI, vec_lvl, bridge_pkg::RST_OP_LO}; // R21 R27
    end else if (panel_op) begin
      st_nxt.cpu_dout = st_r.sy2[bridge_pkg::SY_CP +: 8]; // R14
    end else begin
      st_nxt.cpu_dout = st_r.sy2[bridge_pkg::SY_DI +: 8]; // R15
    end
    // vectored interrupts
    st_nxt.irq_ack_condition_d = irq_ack_condition;
    st_nxt.lvl = vec_lvl; // R20
    // pinte_n lifts for one cycle on the first acknowledge cycle only
    st_nxt.pinte_n = irq_ack_condition_rise; // R26
    st_nxt.pending = |vi_act; // R22 R27
    st_nxt.int_n = !(st_nxt.pending && st_r.cfg_onboard_irq_enable); // R22 R25
    // register port, answer only in the cycle after the read
    st_nxt.rdata = 8'h00;
    // config writes ignore the status offset, which is read only
    if (reg_wr && reg_addr == bridge_pkg::CFG_OFS) begin
      st_nxt.cfg_mirror = reg_wdata[bridge_pkg::CFG_MIRROR_BIT]; // R24
      st_nxt.cfg_onboard_irq_enable = reg_wdata[bridge_pkg::CFG_ONBOARD_IRQ_ENABLE_BIT]; // R25
    end
    if (reg_rd) begin
      unique case (reg_addr)
        bridge_pkg::CFG_OFS: begin
          st_nxt.rdata = {6'h00, st_r.cfg_onboard_irq_enable, st_r.cfg_mirror};
        end
        bridge_pkg::STAT_OFS: begin
          st_nxt.rdata = {2'h0, st_r.shlta, st_r.pwait, st_r.pending, st_r.lvl};
        end
        default: begin
          st_nxt.rdata = bridge_pkg::UNMAPPED_RD;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  // outputs idle at reset: active-low strobes high, except pinte_n, which resets low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      // synchronised pins start high so ready reads true at once
      st_r.sy1 <= {bridge_pkg::SY_W{1'b1}};
      st_r.sy2 <= {bridge_pkg::SY_W{1'b1}};
      st_r.cfg_mirror <= bridge_pkg::CFG_RESET[bridge_pkg::CFG_MIRROR_BIT];
      st_r.cfg_onboard_irq_enable <= bridge_pkg::CFG_RESET[bridge_pkg::CFG_ONBOARD_IRQ_ENABLE_BIT];
      st_r.pwr_n <= 1'b1;
      st_r.panel_oe <= 1'b1;
      st_r.int_n <= 1'b1;
      st_r.sta_oe <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  // wait request is a handshake, kept combinational for speed
  assign cpu_wait_n = ready; // R12 R23
  // every data output leaves straight from a flop
  assign cpu_data_bus = st_r.cpu_dout;
  assign cpu_data_oe = st_r.cpu_doe;
  assign cpu_int_n = st_r.int_n;
  assign bus_addr = st_r.addr;
  assign bus_dout = st_r.bus_dout;
  assign bus_dout_oe = st_r.bus_doe;
  assign panel_data_bus = st_r.panel_dout;
  assign panel_data_oe = st_r.panel_oe;
  assign psync = st_r.psync;
  assign pwait = st_r.pwait;
  assign pwr_n = st_r.pwr_n;
  assign pinte_n = st_r.pinte_n;
  assign smemr = st_r.smemr;
  assign sinp = st_r.sinp;
  assign sout = st_r.sout;
  assign sinta = st_r.sinta;
  assign sm1 = st_r.sm1;
  assign shlta = st_r.shlta;
  assign swo = st_r.swo;
  assign sstack = 1'b0; // R08
  assign status_oe = st_r.sta_oe;
  assign panel_to_cpu_gate = st_r.panel_gate;
  assign bus_in_to_cpu_gate = st_r.bus_gate;
  assign boot_rom_select = st_r.rom_sel;
  assign vector_mux_enable = st_r.mux_en;
  assign any_level_pending = st_r.pending;
  assign reg_rdata = st_r.rdata;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // all checks run on ref_clk and sleep while reset is held
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // strobe and status checks
  chk_sync_between: assert property ((cpu_mreq_n && cpu_iorq_n) |=> psync) // R01
    else $error("psync missing between cycles");
  chk_wait_ready: assert property ((mem_cyc && !ready) |=> pwait) // R02
    else $error("pwait missing in ready wait");
  chk_write_strobe: assert property (!pwr_n |-> swo && bus_dout_oe) // R03
    else $error("write strobe without output data");
  chk_write_data: assert property (wr_cyc |=> !pwr_n && bus_dout == $past(cpu_data_in)) // R16
    else $error("output bus data not the written byte");
  chk_mem_read: assert property ((mem_cyc && !cpu_rd_n) |=> smemr && !sinp && !sout) // R05
    else $error("memory read status wrong");
  chk_io_status: assert property ((io_cyc && !cpu_wr_n) |=> sout && !sinp && !smemr) // R05
    else $error("output status wrong");
  chk_ack_status: assert property (irq_ack_condition |=> sinta && !sinp && !sout) // R06
    else $error("acknowledge status wrong");
  chk_halt_status: assert property (!cpu_halt_n |=> shlta) // R04
    else $error("halt status missing");
  chk_status_release: assert property (!st_r.sy2[bridge_pkg::SY_STA] |=> !status_oe) // R11
    else $error("status drivers not released");
  // address and data path checks
  chk_addr_mirror: assert property ((io_cyc && st_r.cfg_mirror) |=> // R19
      bus_addr[15:8] == bus_addr[7:0])
    else $error("io address not mirrored");
  chk_addr_full: assert property (!io_cyc |=> bus_addr == $past(cpu_address_bus)) // R18
    else $error("address not passed through");
  chk_rom_path: assert property (boot_rom_select |-> !bus_in_to_cpu_gate) // R17
    else $error("input bus on during rom read");
  chk_panel_swap: assert property (panel_to_cpu_gate |-> // R10 R14
      !bus_in_to_cpu_gate && !panel_data_oe)
    else $error("panel and input bus both on");
  // interrupt checks
  chk_vector_code: assert property (vector_mux_enable |-> // R21
      cpu_data_bus[7:6] == 2'h3 && cpu_data_bus[5:3] == st_r.lvl && cpu_data_bus[2:0] == 3'h7)
    else $error("restart opcode malformed");
  chk_mux_in_ack: assert property (vector_mux_enable |-> sinta) // R21
    else $error("vector mux on outside acknowledge");
  chk_pinte_pulse: assert property ((irq_ack_condition && !st_r.irq_ack_condition_d) ##1 irq_ack_condition |-> // R26
      pinte_n ##1 !pinte_n)
    else $error("pinte pulse wrong");
  chk_irq_gate: assert property (!st_r.cfg_onboard_irq_enable |=> cpu_int_n && !vector_mux_enable) // R22
    else $error("interrupt raised while disabled");

  // main scenarios worth seeing at least once
  cov_irq_ack_condition: cover property (vector_mux_enable && any_level_pending);
  cov_panel_read: cover property (panel_to_cpu_gate);
  cov_wait_run: cover property (pwait ##1 !pwait);
  cov_rom_read: cover property (boot_rom_select && smemr);
  cov_io_mirror: cover property (sout && bus_addr[15:8] == bus_addr[7:0]);

endmodule // cpu_backplane_bridge

// >>> verification/backplane_model.sv
`timescale 1ns/1ps
// -------------------------------------------
// far side: one memory/io board and a panel
// -------------------------------------------
module backplane_model (
  input wire logic ref_clk,
  input wire logic [15:0] bus_addr,
  input wire logic smemr,
  input wire logic sinp,
  input wire logic slow, // memory board stretches cycles
  input wire logic stop, // panel stop request
  input wire logic sense, // panel reads its switches
  input wire logic sdis, // panel takes the status lines
  input wire logic [7:0] vreq, // requesting levels, high = on
  output logic prdy,
  output logic xrdy,
  output logic ssw_dsbl,
  output logic sta_dsbl_n,
  output logic [7:0] vi_n,
  output logic [7:0] bus_din,
  output logic [7:0] panel_din
);
  logic [7:0] churn_r = 8'h00; // unselected lines must not look stable
  // free-running pattern for released lines
  always @(posedge ref_clk) begin
    churn_r <= churn_r + 8'h01;
  end
  // a selected board answers with a mark of its address
  always_comb begin
    bus_din = (smemr | sinp) ? (bus_addr[7:0] ^ 8'h5A) : churn_r;
    panel_din = sense ? 8'hC3 : ~churn_r;
  end
  assign prdy = ~slow;
  assign xrdy = ~stop; // only this model drives the line
  assign ssw_dsbl = sense;
  assign sta_dsbl_n = ~sdis;
  assign vi_n = ~vreq;
endmodule // backplane_model

// >>> verification/cpu_backplane_bridge_tb_top.sv
`timescale 1ns/1ps
module cpu_backplane_bridge_tb_top;
  logic ref_clk, rst_b, cpu_halt_n, rom_addr_hit, reg_wr, reg_rd;
  logic slow, stop, sense, sdis;
  logic [4:0] ctl; // m1, mreq, iorq, rd, wr, all active low
  logic [15:0] cpu_address_bus, bus_addr;
  logic [7:0] cpu_data_in, vreq, reg_addr, reg_wdata, reg_rdata, cpu_data_bus;
  logic [7:0] vi_n, bus_din, panel_din, bus_dout, panel_data_bus;
  logic cpu_wait_n, cpu_int_n, prdy, xrdy, ssw_dsbl, sta_dsbl_n, bus_dout_oe;
  logic psync, pwait, pwr_n, pinte_n, smemr, sinp, sout, sinta, sm1, shlta, swo;
  logic sstack, status_oe, panel_to_cpu_gate, bus_in_to_cpu_gate;
  logic boot_rom_select, vector_mux_enable, any_level_pending, cpu_data_oe, panel_data_oe;
  int fails = 0;
  int checks = 0;
  localparam logic [4:0] IDLE = 5'h1F, FETCH = 5'h05, MRD = 5'h15, MWR = 5'h16;
  localparam logic [4:0] IORD = 5'h19, IOWR = 5'h1A, ACK = 5'h0B;

  cpu_backplane_bridge i_dut (.ref_clk, .rst_b, .cpu_address_bus, .cpu_data_in,
    .cpu_m1_n(ctl[4]), .cpu_mreq_n(ctl[3]), .cpu_iorq_n(ctl[2]), .cpu_rd_n(ctl[1]),
    .cpu_wr_n(ctl[0]), .cpu_halt_n, .rom_addr_hit, .cpu_data_bus, .cpu_data_oe,
    .cpu_wait_n, .cpu_int_n, .prdy, .xrdy, .ssw_dsbl, .sta_dsbl_n, .vi_n, .bus_din,
    .panel_din, .bus_addr, .bus_dout, .bus_dout_oe, .panel_data_bus, .panel_data_oe,
    .psync, .pwait, .pwr_n, .pinte_n, .smemr, .sinp, .sout, .sinta, .sm1, .shlta, .swo,
    .sstack, .status_oe, .panel_to_cpu_gate, .bus_in_to_cpu_gate, .boot_rom_select,
    .vector_mux_enable, .any_level_pending, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  backplane_model i_far (.ref_clk, .bus_addr, .smemr, .sinp, .slow, .stop, .sense,
    .sdis, .vreq, .prdy, .xrdy, .ssw_dsbl, .sta_dsbl_n, .vi_n, .bus_din, .panel_din);

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one processor cycle held for n edges, sampled just after the last
  task automatic cyc(input logic [4:0] c, input logic [15:0] a, input int n);
    @(posedge ref_clk);
    ctl <= c;
    cpu_address_bus <= a;
    cpu_data_in <= a[15:8];
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_idle_regs;
    chk({psync, pinte_n, sstack, cpu_int_n, pwr_n}, 5'h13);
    reg_read(bridge_pkg::CFG_OFS, {6'h00, bridge_pkg::CFG_RESET});
    reg_write(bridge_pkg::STAT_OFS, 8'hFF); // read-only place
    reg_read(8'h08, bridge_pkg::UNMAPPED_RD);
  endtask
  task automatic t_reads;
    cyc(FETCH, 16'hBE34, 6);
    chk({smemr, sm1, psync, sinp, sout, swo, pwr_n, bus_in_to_cpu_gate}, 8'hC3);
    chk(bus_addr, 16'hBE34);
    chk(cpu_data_bus, 8'h6E);
    chk(cpu_data_oe, 1'b1);
    cyc(IDLE, 16'hBE35, 1);
    chk({sm1, psync, smemr}, 3'h2);
    cyc(FETCH, 16'hBE35, 1);
    chk(sm1, 1'b1); // second opcode byte
    rom_addr_hit <= 1'b1;
    cyc(MRD, 16'h0400, 2);
    chk({boot_rom_select, bus_in_to_cpu_gate, smemr, sm1}, 4'hA);
    chk(cpu_data_oe, 1'b0);
    rom_addr_hit <= 1'b0;
  endtask
  task automatic t_writes;
    cyc(MWR, 16'hA657, 1);
    chk({pwr_n, swo, bus_dout_oe, smemr, psync}, 5'h0C);
    chk(bus_dout, 8'hA6);
    chk({panel_data_oe, panel_data_bus}, 9'h1A6);
    cyc(IOWR, 16'h1234, 1);
    chk({sout, pwr_n, swo, sinp}, 4'hA);
    chk(bus_addr, 16'h3434); // mirrored port address
    reg_write(bridge_pkg::CFG_OFS, 8'h02);
    cyc(IOWR, 16'h1234, 1);
    chk(bus_addr, 16'h1234);
    reg_write(bridge_pkg::CFG_OFS, 8'h03);
  endtask
  task automatic t_panel;
    sense <= 1'b1;
    cyc(IORD, 16'h00FF, 5);
    chk({sinp, panel_to_cpu_gate, bus_in_to_cpu_gate}, 3'h6);
    chk(cpu_data_bus, 8'hC3);
    chk({panel_data_oe, cpu_data_oe}, 2'h1);
    sense <= 1'b0;
    cyc(IORD, 16'h0011, 5);
    chk({panel_to_cpu_gate, bus_in_to_cpu_gate}, 2'h1);
    chk(cpu_data_bus, 8'h4B);
  endtask
  // level 7 always requests, so each pass for levels 0 to 6 also checks priority
  task automatic t_irq;
    for (int i = 0; i < 8; i++) begin
      vreq <= 8'h80 | (8'h01 << i);
      cyc(IDLE, 16'h0000, 4);
      chk({any_level_pending, cpu_int_n}, 2'h2);
      cyc(ACK, 16'h1200, 1);
      chk(bus_addr, 16'h1200);
      chk({sinta, vector_mux_enable, pinte_n}, 3'h7);
      chk(cpu_data_bus, {bridge_pkg::RST_OP_HI, 3'(i), bridge_pkg::RST_OP_LO});
      @(posedge ref_clk);
      #1;
      chk(pinte_n, 1'b0);
    end
    cyc(IDLE, 16'h0000, 1);
    reg_read(bridge_pkg::STAT_OFS, 8'h0F);
    reg_write(bridge_pkg::CFG_OFS, 8'h01);
    cyc(IDLE, 16'h0000, 2);
    chk({any_level_pending, cpu_int_n}, 2'h3);
    cyc(ACK, 16'h0000, 1);
    chk({sinta, vector_mux_enable, cpu_data_oe}, 3'h4);
    cyc(IDLE, 16'h0000, 1);
    reg_write(bridge_pkg::CFG_OFS, 8'h03);
    vreq <= 8'h00;
  endtask
  task automatic t_wait;
    slow <= 1'b1;
    cyc(MRD, 16'h2000, 4);
    chk({pwait, cpu_wait_n}, 2'h2);
    reg_read(bridge_pkg::STAT_OFS, 8'h17);
    slow <= 1'b0;
    stop <= 1'b1;
    cyc(MRD, 16'h2001, 4);
    chk({pwait, cpu_wait_n}, 2'h2);
    stop <= 1'b0;
    cyc(MRD, 16'h2002, 4);
    chk({pwait, cpu_wait_n}, 2'h1);
  endtask
  task automatic t_halt_sta;
    cpu_halt_n <= 1'b0;
    cyc(FETCH, 16'h0076, 1);
    chk(shlta, 1'b1);
    sdis <= 1'b1;
    cyc(IDLE, 16'h0077, 4);
    chk({status_oe, sstack}, 2'h0);
    sdis <= 1'b0;
    cpu_halt_n <= 1'b1;
    cyc(IDLE, 16'h0077, 4);
    chk({status_oe, shlta}, 2'h2);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    rst_b = 1'b0; cpu_halt_n = 1'b1; rom_addr_hit = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    slow = 1'b0; stop = 1'b0; sense = 1'b0; sdis = 1'b0; vreq = 8'h00; ctl = IDLE;
    cpu_address_bus = 16'h0000; cpu_data_in = 8'h00; reg_addr = 8'h00; reg_wdata = 8'h00;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    t_idle_regs();
    t_reads();
    t_writes();
    t_panel();
    t_irq();
    t_wait();
    t_halt_sta();
    tally_and_finish();
  end
endmodule // cpu_backplane_bridge_tb_top
